// file: cosd_top.sv
// Auto-shutdown and dead-band stage of the complementary waveform generator, AXI4-Lite slave.
// Assumes wave_in, polarity and limit timer values come from logic on aclk; pins are asynchronous.
//
// Chosen here: the address map and register access over AXI4-Lite.
module cosd_top
  import cosd_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              wave_in,
  input  wire logic              out0_polarity,
  input  wire logic              out1_polarity,
  input  wire logic              fault_input_pin,
  input  wire logic              comparator1_out,
  input  wire logic              comparator2_out,
  input  wire logic [LT_W-1:0]   limit_timer1_count,
  input  wire logic [LT_W-1:0]   limit_timer1_period,
  input  wire logic [LT_W-1:0]   limit_timer2_count,
  input  wire logic [LT_W-1:0]   limit_timer2_period,
  output logic                   primary_output,
  output logic                   primary_output_oe,
  output logic                   complementary_output,
  output logic                   complementary_output_oe,
  output logic                   irq
);
  logic              awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0]        bresp_r, rresp_r, lvl1_r, lvl0_r, cfg_r;
  logic [DATA_W-1:0] rdata_r, wdata_r, rd_mux;
  logic [ADDR_W-1:0] awaddr_r, wr_word, rd_word;
  logic [3:0]        wstrb_r;
  logic              aw_have_r, w_have_r, aw_take, w_take, ar_take, wr_fire;
  logic              aw_have_nxt, w_have_nxt, bvalid_nxt, rvalid_nxt;
  logic              wr_ctrl, wr_src, wr_dbr, wr_dbf, wr_cfg, wr_sts, wr_mask, wr_hit;
  logic              flag_r, auto_r, rd_hit, wave_d_r, rise_ev, trip, chain_tick;
  logic [SRC_W-1:0]  src_en_r, src_act;
  logic [DB_W-1:0]   dbr_r, dbf_r, chain_cnt_r;
  logic [IRQ_W-1:0]  sts_r, mask_r, sts_set;
  logic [2:0]        pin_s1_r, pin_s2_r;
  logic              irq_r, p_out_r, p_oe_r, c_out_r, c_oe_r;
  cosd_state_t       state_r, state_nxt;

  cosd_db_if db_rise ();
  cosd_db_if db_fall ();

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign primary_output          = p_out_r;
  assign primary_output_oe       = p_oe_r;
  assign complementary_output    = c_out_r;
  assign complementary_output_oe = c_oe_r;
  assign irq = irq_r;

  // Write channel: address and data are taken in either order, one write at a time.
  assign aw_take = s_axi_awvalid && awready_r;
  assign w_take  = s_axi_wvalid && wready_r;
  assign wr_fire = aw_have_r && w_have_r && !bvalid_r;
  assign wr_word = awaddr_r & ADDR_WORD_MASK;
  assign wr_ctrl = wr_fire && wr_word == OFS_CTRL_MAIN && wstrb_r[0];
  assign wr_src  = wr_fire && wr_word == OFS_SRC_EN && wstrb_r[0];
  assign wr_dbr  = wr_fire && wr_word == OFS_DB_RISE && wstrb_r[0];
  assign wr_dbf  = wr_fire && wr_word == OFS_DB_FALL && wstrb_r[0];
  assign wr_cfg  = wr_fire && wr_word == OFS_DB_CFG && wstrb_r[0];
  assign wr_sts  = wr_fire && wr_word == OFS_IRQ_STS && wstrb_r[0];
  assign wr_mask = wr_fire && wr_word == OFS_IRQ_MASK && wstrb_r[0];
  assign wr_hit  = wr_word <= OFS_SRC_LIVE;

  always_comb begin
    aw_have_nxt = wr_fire ? 1'b0 : (aw_have_r || aw_take);
    w_have_nxt  = wr_fire ? 1'b0 : (w_have_r || w_take);
    bvalid_nxt  = wr_fire ? 1'b1 : (bvalid_r && !s_axi_bready);
    rvalid_nxt  = ar_take ? 1'b1 : (rvalid_r && !s_axi_rready);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= 4'h0;
    end else begin
      aw_have_r <= aw_have_nxt;
      w_have_r  <= w_have_nxt;
      awready_r <= !aw_have_nxt && !bvalid_nxt;
      wready_r  <= !w_have_nxt && !bvalid_nxt;
      bvalid_r  <= bvalid_nxt;
      if (aw_take) begin
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Read channel: one read at a time, data registered on the same edge that takes the address.
  assign ar_take = s_axi_arvalid && arready_r;
  assign rd_word = s_axi_araddr & ADDR_WORD_MASK;

  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    case (rd_word)
      OFS_CTRL_MAIN: rd_mux = {24'h000000, flag_r, auto_r, lvl1_r, lvl0_r, 2'h0};
      OFS_SRC_EN:    rd_mux = {27'h0000000, src_en_r};
      OFS_DB_RISE:   rd_mux = {28'h0000000, dbr_r};
      OFS_DB_FALL:   rd_mux = {28'h0000000, dbf_r};
      OFS_DB_CFG:    rd_mux = {30'h00000000, cfg_r};
      OFS_IRQ_STS:   rd_mux = {30'h00000000, sts_r};
      OFS_IRQ_MASK:  rd_mux = {30'h00000000, mask_r};
      OFS_SRC_LIVE:  rd_mux = {27'h0000000, src_act};
      default:       rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= RESP_OKAY;
    end else begin
      arready_r <= !rvalid_nxt;
      rvalid_r  <= rvalid_nxt;
      if (ar_take) begin
        rdata_r <= rd_mux;
        rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Pins and comparator outputs are asynchronous; only the second stage is read.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_r <= 3'h7;
      pin_s2_r <= 3'h7;
    end else begin
      pin_s1_r <= {comparator2_out, comparator1_out, fault_input_pin};
      pin_s2_r <= pin_s1_r;
    end
  end

  always_comb begin
    src_act          = '0;
    src_act[SRC_FLT] = !pin_s2_r[0];
    src_act[SRC_C1]  = !pin_s2_r[1];
    src_act[SRC_C2]  = !pin_s2_r[2];
    src_act[SRC_LT1] = limit_timer1_count == limit_timer1_period;
    src_act[SRC_LT2] = limit_timer2_count == limit_timer2_period;
  end

  // A disabled source is masked out here, so it never reaches the flag.
  assign trip = |(src_act & src_en_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_en_r <= RST_SRC_EN;
    end else if (wr_src) begin
      src_en_r <= wdata_r[SRC_W-1:0];
    end
  end

  // A live source beats a software clear; auto-restart drops the flag once all are quiet.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_r <= 1'b0;
    end else if (trip) begin
      flag_r <= 1'b1;
    end else if (wr_ctrl) begin
      flag_r <= wdata_r[BIT_FLAG];
    end else if (auto_r) begin
      flag_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      auto_r <= 1'b0;
      lvl1_r <= RST_LVL;
      lvl0_r <= RST_LVL;
    end else if (wr_ctrl) begin
      auto_r <= wdata_r[BIT_AUTO];
      lvl1_r <= wdata_r[LVL1_LSB +: 2];
      lvl0_r <= wdata_r[LVL0_LSB +: 2];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dbr_r <= RST_DB;
      dbf_r <= RST_DB;
      cfg_r <= RST_CFG;
    end else begin
      if (wr_dbr) dbr_r <= wdata_r[DB_W-1:0];
      if (wr_dbf) dbf_r <= wdata_r[DB_W-1:0];
      if (wr_cfg) cfg_r <= wdata_r[1:0];
    end
  end

  // Pulsed falling sources arrive already phase-delayed upstream, so edge and level mode look alike here.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wave_d_r <= 1'b0;
    end else begin
      wave_d_r <= wave_in;
    end
  end
  assign rise_ev = wave_in && !wave_d_r;

  // Outputs stay held after the flag drops until the next rising event, so no runt pulse escapes.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN:  if (flag_r) state_nxt = ST_HOLD;
      ST_HOLD: if (!flag_r) state_nxt = ST_WAIT;
      ST_WAIT: begin
        if (flag_r) begin
          state_nxt = ST_HOLD;
        end else if (rise_ev) begin
          state_nxt = ST_RUN;
        end
      end
      default: state_nxt = ST_HOLD;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Delay-chain elements are modelled as ticks of a divider on aclk.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chain_cnt_r <= RST_DB;
    end else if (chain_tick) begin
      chain_cnt_r <= RST_DB;
    end else begin
      chain_cnt_r <= chain_cnt_r + 4'h1;
    end
  end
  assign chain_tick = chain_cnt_r >= DB_W'(CHAIN_DIV - 1);

  assign db_rise.level_in   = wave_in;
  assign db_rise.count      = dbr_r;
  assign db_rise.tb_sel     = cfg_r[CFG_RISE_TB];
  assign db_rise.chain_tick = chain_tick;
  assign db_fall.level_in   = !wave_in;
  assign db_fall.count      = dbf_r;
  assign db_fall.tb_sel     = cfg_r[CFG_FALL_TB];
  assign db_fall.chain_tick = chain_tick;

  cosd_deadband u_db_rise (
    .aclk    (aclk),
    .aresetn (aresetn),
    .db      (db_rise)
  );

  cosd_deadband u_db_fall (
    .aclk    (aclk),
    .aresetn (aresetn),
    .db      (db_fall)
  );

  function automatic logic [1:0] cosd_drive(input logic [1:0] ovr, input logic pol);
    case (ovr)
      OVR_ZERO:  return 2'b10;
      OVR_ONE:   return 2'b11;
      OVR_INACT: return {1'b1, pol};
      default:   return 2'b00;
    endcase
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {p_oe_r, p_out_r} <= 2'b00;
      {c_oe_r, c_out_r} <= 2'b00;
    end else if (state_r != ST_RUN) begin
      {p_oe_r, p_out_r} <= cosd_drive(lvl0_r, out0_polarity);
      {c_oe_r, c_out_r} <= cosd_drive(lvl1_r, out1_polarity);
    end else begin
      {p_oe_r, p_out_r} <= {1'b1, db_rise.level_out ^ out0_polarity};
      {c_oe_r, c_out_r} <= {1'b1, db_fall.level_out ^ out1_polarity};
    end
  end

  // Interrupt status: a new event wins over a write-one-to-clear in the same cycle.
  always_comb begin
    sts_set             = '0;
    sts_set[IRQ_ENTER]  = state_r == ST_RUN && state_nxt == ST_HOLD;
    sts_set[IRQ_RESUME] = state_r == ST_WAIT && state_nxt == ST_RUN;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sts_r  <= RST_IRQ;
      mask_r <= RST_IRQ;
      irq_r  <= 1'b0;
    end else begin
      sts_r <= (sts_r & ~(wr_sts ? wdata_r[IRQ_W-1:0] : RST_IRQ)) | sts_set;
      if (wr_mask) mask_r <= wdata_r[IRQ_W-1:0];
      irq_r <= |(sts_r & mask_r);
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_fault_pin_trip: assert property (src_en_r[SRC_FLT] && !pin_s2_r[0] |=> flag_r)
    else $error("Low fault pin did not set the shutdown flag.");
  a_cmp1_low_trip: assert property (src_en_r[SRC_C1] && !pin_s2_r[1] |=> flag_r)
    else $error("Low comparator 1 did not set the shutdown flag.");
  a_cmp2_low_trip: assert property (src_en_r[SRC_C2] && !pin_s2_r[2] |=> flag_r)
    else $error("Low comparator 2 did not set the shutdown flag.");
  a_lt1_trip: assert property (src_en_r[SRC_LT1] && limit_timer1_count == limit_timer1_period |=> flag_r)
    else $error("Limit timer 1 match did not set the shutdown flag.");
  a_lt2_trip: assert property (src_en_r[SRC_LT2] && limit_timer2_count == limit_timer2_period |=> flag_r)
    else $error("Limit timer 2 match did not set the shutdown flag.");
  a_flag_holds_out: assert property (flag_r |=> state_r != ST_RUN)
    else $error("Shutdown flag set but outputs not held.");
  a_resume_on_rise: assert property (state_r == ST_WAIT && !flag_r && rise_ev |=> state_r == ST_RUN)
    else $error("Held outputs did not resume at the rising event.");
  a_auto_clear_flag: assert property (flag_r && auto_r && !trip && !wr_ctrl |=> !flag_r)
    else $error("Auto-restart did not clear the quiet shutdown flag.");
  a_manual_keep_flag: assert property (flag_r && !auto_r && !wr_ctrl |=> flag_r)
    else $error("Shutdown flag cleared without software or auto-restart.");
  a_hiz_override: assert property (state_r != ST_RUN && lvl0_r == OVR_HIZ |=> !p_oe_r)
    else $error("Primary output driven while tri-state override held.");
  a_one_override: assert property (state_r != ST_RUN && lvl1_r == OVR_ONE |=> c_oe_r && c_out_r)
    else $error("Complementary output not one under override.");
  a_db_upper_zero: assert property (ar_take && rd_word == OFS_DB_RISE |=> rdata_r[DATA_W-1:DB_W] == '0)
    else $error("Upper bits of the rising dead-band count read non-zero.");
endmodule

// file: cosd_pkg.sv
// Constants, register map and types of the shutdown and dead-band block.
// Assumes one clock domain; every module but the gate model imports the whole package.
// Function
// - With its enable set, limit timer 2 count equal to its period forces shutdown; otherwise it is ignored.
// - With its enable set, limit timer 1 count equal to its period forces shutdown; otherwise it is ignored.
// - With its enable set, a low comparator 2 output forces shutdown; otherwise it has no effect.
// - With its enable set, a low comparator 1 output forces shutdown; otherwise it has no effect.
// - With its enable set, a low fault input pin forces shutdown; otherwise the pin is ignored.
// - With the rising timebase select set, the primary output is delayed by the rising count in chain elements.
// - With the rising timebase select clear, the primary output is delayed by the rising count in clock periods.
// - Unused upper bits of the dead-band counts and source enables ignore writes and read as zero.
// - Pulsed falling sources in edge mode differ from level mode only by the falling phase delay.
// - The falling count delays the complementary output in chain elements or clock periods by its select.
package cosd_pkg;
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned SRC_W         = 5;
  localparam int unsigned DB_W          = 4;
  localparam int unsigned LT_W          = 8;
  localparam int unsigned IRQ_W         = 2;
  localparam int unsigned CHAIN_DIV     = 1;
  localparam logic [7:0] OFS_CTRL_MAIN  = 8'h00;
  localparam logic [7:0] OFS_SRC_EN     = 8'h04;
  localparam logic [7:0] OFS_DB_RISE    = 8'h08;
  localparam logic [7:0] OFS_DB_FALL    = 8'h0C;
  localparam logic [7:0] OFS_DB_CFG     = 8'h10;
  localparam logic [7:0] OFS_IRQ_STS    = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h18;
  localparam logic [7:0] OFS_SRC_LIVE   = 8'h1C;
  localparam logic [7:0] ADDR_WORD_MASK = 8'hFC;
  localparam int unsigned BIT_FLAG      = 7;
  localparam int unsigned BIT_AUTO      = 6;
  localparam int unsigned LVL1_LSB      = 4;
  localparam int unsigned LVL0_LSB      = 2;
  localparam int unsigned SRC_FLT       = 0;
  localparam int unsigned SRC_C1        = 1;
  localparam int unsigned SRC_C2        = 2;
  localparam int unsigned SRC_LT1       = 3;
  localparam int unsigned SRC_LT2       = 4;
  localparam int unsigned CFG_RISE_TB   = 0;
  localparam int unsigned CFG_FALL_TB   = 1;
  localparam int unsigned IRQ_ENTER     = 0;
  localparam int unsigned IRQ_RESUME    = 1;
  localparam logic [1:0] RST_LVL        = 2'h0;
  localparam logic [SRC_W-1:0] RST_SRC_EN = 5'h00;
  localparam logic [DB_W-1:0] RST_DB    = 4'h0;
  localparam logic [1:0] RST_CFG        = 2'h0;
  localparam logic [IRQ_W-1:0] RST_IRQ  = 2'h0;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;
  typedef enum logic [1:0] {
    OVR_ZERO  = 2'h0,
    OVR_ONE   = 2'h1,
    OVR_INACT = 2'h2,
    OVR_HIZ   = 2'h3
  } cosd_ovr_t;
  typedef enum logic [1:0] {
    ST_RUN  = 2'h0,
    ST_HOLD = 2'h1,
    ST_WAIT = 2'h3
  } cosd_state_t;
endpackage

// file: cosd_db_if.sv
// Carrier between the shutdown block and one dead-band delay unit.
// Assumes both ends run on the same clock.
interface cosd_db_if;
  import cosd_pkg::*;
  logic            level_in;
  logic [DB_W-1:0] count;
  logic            tb_sel;
  logic            chain_tick;
  logic            level_out;
  modport drv (output level_in, output count, output tb_sel, output chain_tick, input level_out);
  modport dly (input level_in, input count, input tb_sel, input chain_tick, output level_out);
endinterface

// file: cosd_deadband.sv
// Dead-band unit: delays the rising edge of its input, passes the falling edge at once.
// Assumes the driver holds count and select steady while a delay runs.
module cosd_deadband
  import cosd_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  cosd_db_if.dly    db
);
  logic [DB_W-1:0] cnt_r;
  logic            out_r;
  logic            tick;

  assign tick = db.tb_sel ? db.chain_tick : 1'b1;
  assign db.level_out = out_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= RST_DB;
      out_r <= 1'b0;
    end else if (!db.level_in) begin
      cnt_r <= RST_DB;
      out_r <= 1'b0;
    end else if (!out_r) begin
      if (cnt_r >= db.count) begin
        out_r <= 1'b1;
      end else if (tick) begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_db_early_block: assert property (db.level_in && !out_r && cnt_r < db.count |=> !out_r)
    else $error("Dead-band output rose before its count elapsed.");
  a_db_fall_pass: assert property (!db.level_in |=> !out_r)
    else $error("Dead-band output stayed high after its input fell.");
endmodule

// file: cosd_gate_model.sv
// Gate drive model of the two external power switches behind the output pins.
// Assumes pull-downs on both gates, so a tri-stated pin turns its switch off.
module cosd_gate_model (
  input  wire logic out0,
  input  wire logic oe0,
  input  wire logic out1,
  input  wire logic oe1,
  output logic      gate0,
  output logic      gate1
);
  timeunit 1ns;
  timeprecision 1ns;
  // The pull-down decides a released pin, so no stale level can leak through.
  assign gate0 = oe0 ? out0 : 1'b0;
  assign gate1 = oe1 ? out1 : 1'b0;
endmodule

// file: tb_complementary_output_shutdown_deadband.sv
// Self-checking bench of the shutdown and dead-band block.
// Assumes one 10 MHz clock; results are checked by a monitor against a queue of notes.
module tb_complementary_output_shutdown_deadband
  import cosd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {string nm; logic [33:0] v;} cosd_exp_t;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, smp;
  logic        arvalid, arready, rvalid, rready, wave, pol0, pol1, flt, cmp1, cmp2;
  logic        out0, oe0, out1, oe1, irq, gate0, gate1;
  logic [7:0]  awaddr, araddr, lc1, lp1, lc2, lp2;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, o0, o1;
  logic [3:0]  wstrb;
  int          errors, n_tests, cyc;
  integer      seed;
  cosd_exp_t   q[$];

  cosd_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .wave_in(wave),
    .out0_polarity(pol0), .out1_polarity(pol1), .fault_input_pin(flt), .comparator1_out(cmp1),
    .comparator2_out(cmp2), .limit_timer1_count(lc1), .limit_timer1_period(lp1),
    .limit_timer2_count(lc2), .limit_timer2_period(lp2), .primary_output(out0),
    .primary_output_oe(oe0), .complementary_output(out1), .complementary_output_oe(oe1), .irq(irq));
  cosd_gate_model gates (.out0(out0), .oe0(oe0), .out1(out1), .oe1(oe1), .gate0(gate0), .gate1(gate1));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic stop_test();
    $display("TB: counts errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [33:0] v);
    cosd_exp_t e;
    n_tests++;
    if (q.size() == 0) begin
      errors++;
      $display("ERROR unexpected result expected none seen %h", v);
    end else begin
      e = q.pop_front();
      if (e.v !== v) begin
        errors++;
        $display("ERROR %s expected %h seen %h", e.nm, e.v, v);
      end
    end
  endtask

  // Results are judged at the edge after the one that presents them, so no sampling race exists.
  always @(posedge aclk) begin
    if (aresetn && rvalid && rready) chk({rresp, rdata});
    if (aresetn && bvalid && bready) chk({bresp, 32'h0});
    if (aresetn && smp) chk({29'h0, irq, gate1, gate0, oe1, oe0});
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      stop_test();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    q.push_back('{$sformatf("write %h", a), {r, 32'h0}});
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    q.push_back('{$sformatf("read %h", a), {r, d}});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask

  task automatic pin(input logic [4:0] a, input logic [4:0] b, input int k);
    q.push_back('{"pins", {29'h0, a}});
    if (k == 2) q.push_back('{"pins", {29'h0, b}});
    smp <= 1'b1;
    repeat (k) @(posedge aclk);
    smp <= 1'b0;
  endtask

  task automatic src(input int i, input bit a);
    @(posedge aclk);
    case (i)
      0: flt <= !a;
      1: cmp1 <= !a;
      2: cmp2 <= !a;
      3: lc1 <= a ? lp1 : lp1 + 8'h01;
      default: lc2 <= a ? lp2 : lp2 + 8'h01;
    endcase
    repeat (6) @(posedge aclk);
  endtask

  task automatic db(input bit r, input int n, input logic [4:0] b);
    @(posedge aclk);
    wave <= r;
    repeat (n + 1) @(posedge aclk);
    pin(5'h03, b, 2);
    repeat (20) @(posedge aclk);
  endtask

  function automatic logic [1:0] ov(input int k, input logic p);
    return {(k == 1) || (k == 2 && p), k != 3};
  endfunction

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, wave, pol0, pol1, smp, aresetn} = '0;
    {flt, cmp1, cmp2} = 3'h7;
    wstrb = 4'hF;
    {awaddr, araddr, wdata, errors, n_tests, cyc} = '0;
    seed = 32'h7652BBE7;
    lp1 = 8'($random(seed));
    lp2 = 8'($random(seed));
    lc1 = lp1 + 8'h01;
    lc2 = lp2 + 8'h01;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++) rd(8'(4 * i), 32'h0);
    rd(8'h20, 32'h0, RESP_SLVERR);
    wr(8'h20, 32'hFFFFFFFF, RESP_SLVERR);
    for (int i = 1; i < 4; i++) begin
      wr(8'(4 * i), 32'hFFFFFFFF);
      rd(8'(4 * i), i == 1 ? 32'h1F : 32'h0F);
    end
    // A write whose lowest byte lane is off must leave the register alone.
    wstrb <= 4'hE;
    wr(OFS_DB_RISE, 32'h1);
    wstrb <= 4'hF;
    rd(OFS_DB_RISE, 32'hF);
    for (int i = 0; i < SRC_W; i++) begin
      wr(OFS_SRC_EN, 32'h1 << i);
      src(i, 1'b1);
      src(i, 1'b0);
      rd(OFS_CTRL_MAIN, 32'h80);
      wr(OFS_CTRL_MAIN, 32'h0);
      wr(OFS_SRC_EN, ~(32'h1 << i) & 32'h1F);
      src(i, 1'b1);
      rd(OFS_CTRL_MAIN, 32'h0);
      src(i, 1'b0);
    end
    wr(OFS_SRC_EN, 32'h0);
    rd(OFS_IRQ_STS, 32'h1);
    wr(OFS_IRQ_MASK, 32'h1);
    pin(5'h13, 5'h0, 1);
    wr(OFS_IRQ_STS, 32'h1);
    pin(5'h03, 5'h0, 1);
    wr(OFS_IRQ_MASK, 32'h0);
    pol0 <= 1'($random(seed));
    pol1 <= 1'($random(seed));
    for (int k = 0; k < 4; k++) begin
      wr(OFS_CTRL_MAIN, 32'h80 | ((3 - k) << 4) | (k << 2));
      repeat (4) @(posedge aclk);
      o0 = ov(k, pol0);
      o1 = ov(3 - k, pol1);
      pin({1'b0, o1[1], o0[1], o1[0], o0[0]}, 5'h0, 1);
    end
    pol0 <= 1'b0;
    pol1 <= 1'b0;
    wr(OFS_CTRL_MAIN, 32'h0);
    wr(OFS_SRC_EN, 32'h1);
    wr(OFS_CTRL_MAIN, 32'h40);
    src(0, 1'b1);
    rd(OFS_CTRL_MAIN, 32'hC0);
    src(0, 1'b0);
    rd(OFS_CTRL_MAIN, 32'h40);
    pin(5'h03, 5'h0, 1);
    // Both dead-band counts still hold 15 from the earlier all-ones writes.
    db(1'b1, 15, 5'h07);
    db(1'b0, 15, 5'h0B);
    // Re-entry from the waiting state is not a new entry, so only the resume bit is set.
    rd(OFS_IRQ_STS, 32'h2);
    wr(OFS_SRC_EN, 32'h0);
    for (int s = 0; s < 2; s++) begin
      wr(OFS_DB_RISE, s ? 32'hF : 32'h3);
      wr(OFS_DB_FALL, s ? 32'hF : 32'h5);
      wr(OFS_DB_CFG, s ? 32'h3 : 32'h0);
      db(1'b1, (s ? 15 : 3) * CHAIN_DIV, 5'h07);
      db(1'b0, (s ? 15 : 5) * CHAIN_DIV, 5'h0B);
    end
    repeat (5) @(posedge aclk);
    stop_test();
  end
endmodule
